//--- hdl/dmio_top.sv
`timescale 1ns/100ps
// ****************************************************************
// Digital multiboard I/O control
// ****************************************************************
// How it works
// - Inputs recorded only as whole 16-bit word
// - Short HIGH pulse shows in next word
// - Open range select means 24 V range
// - Outputs high impedance after reset, both off
// - Prepare write activates outputs with chosen type
// - Push-pull LOW init never shows HIGH first
// - Prepare loads LOW unless other value given
// - One select sets all eight outputs' type
// - Push-pull: 0 low rail, 1 supply
// - Open-drain: HIGH is off, LOW sinks
// - Counters wait for first index rise
// - Index wait ignores start-trigger release state
// - Index wait re-armed at every start
module dmio_top (
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    // Register bus
    input  wire dmio_pkg::dmio_wb_req_t       wb_req_i,
    output dmio_pkg::dmio_wb_rsp_t            wb_rsp_o,
    // Digital inputs
    input  wire logic [dmio_pkg::DIN_W-1:0]   din_i,
    input  wire logic [dmio_pkg::GRP_N-1:0]   range_sel_n_i,
    output logic [dmio_pkg::GRP_N-1:0]        range_5v_o,
    // Digital outputs
    input  wire logic                         driver_type_select_i,
    output logic [dmio_pkg::DOUT_W-1:0]       drv_high_o,
    output logic [dmio_pkg::DOUT_W-1:0]       drv_low_o,
    // Incremental counters
    input  wire logic                         index_i,
    input  wire logic                         start_trig_released_i,
    output logic [dmio_pkg::ENC_N-1:0]        cnt_enable_o
);
    localparam int unsigned LW = $clog2(dmio_pkg::FIFO_D+1);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic                          ack;        // Bus answer
        logic [31:0]                   rdat;       // Bus read data
        logic                          no_index;   // No-index mode
        logic [dmio_pkg::DIV_W-1:0]    div;        // Interval length - 1
        logic [dmio_pkg::DIV_W-1:0]    tick_cnt;   // Interval countdown
        logic                          measuring;  // Acquisition running
        logic [dmio_pkg::DOUT_W-1:0]   init_val;   // Value for prepare
        logic [dmio_pkg::DOUT_W-1:0]   dout;       // Output value
        logic                          out_act;    // Outputs driven
        logic                          od_mode;    // Latched driver type
        logic [dmio_pkg::DOUT_W-1:0]   hs;         // High-side switches
        logic [dmio_pkg::DOUT_W-1:0]   ls;         // Low-side switches
        logic [dmio_pkg::ENC_N-1:0]    cnt_en;     // Counter enables
        logic                          idx_arm;    // Waiting for index
        logic                          idx_prev;   // Index last cycle
        logic [dmio_pkg::GRP_N-1:0]    rng5;       // 5 V range flags
        logic                          overrun;    // Word refused
    } dmio_st_t;

    dmio_st_t s;
    dmio_st_t next_s;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Word-aligned register hit
    function automatic logic dmio_hit(input logic [dmio_pkg::ADR_W-1:0] adr,
                                      input logic [dmio_pkg::ADR_W-1:0] off);
        dmio_hit = (adr[dmio_pkg::ADR_W-1:2] == off[dmio_pkg::ADR_W-1:2]);
    endfunction : dmio_hit

    // Byte-lane merge of a write into an old value
    function automatic logic [31:0] dmio_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        dmio_merge = r;
    endfunction : dmio_merge

    // Switch pair for one output bit: {high side, low side}
    function automatic logic [1:0] dmio_drive(input logic val,
                                              input logic od,
                                              input logic act);
        if (!act) begin
            dmio_drive = 2'h0;
        end else if (od) begin
            dmio_drive = val ? 2'h0 : 2'h1;
        end else begin
            dmio_drive = val ? 2'h2 : 2'h1;
        end
    endfunction : dmio_drive

    // ****************************************************************
    // Input capture and sample buffer
    // ****************************************************************
    logic                          tick;       // Interval ends now
    logic [dmio_pkg::DIN_W-1:0]    word;       // Captured port word
    logic                          buf_ready;  // Buffer has room
    logic                          buf_valid;  // Buffer holds a word
    logic                          buf_pop;    // Bus takes a word
    logic [dmio_pkg::DIN_W-1:0]    buf_word;   // Oldest word
    logic [LW-1:0]                 buf_lvl;    // Words held
    logic                          req;        // New bus request
    logic                          wr;         // Write request
    logic                          rd;         // Read request

    assign tick = s.measuring && (s.tick_cnt == '0);
    assign req  = wb_req_i.cyc && wb_req_i.stb && !s.ack;
    assign wr   = req && wb_req_i.we;
    assign rd   = req && !wb_req_i.we;
    assign buf_pop = rd && dmio_hit(wb_req_i.adr, dmio_pkg::ADR_DATA);

    // The whole port is captured as one word; no bit selection exists
    dmio_capture #(
        .W        (dmio_pkg::DIN_W)
    ) u_capture (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .din_i    (din_i),
        .tick_i   (tick),
        .accept_i (buf_ready),
        .word_o   (word)
    );

    // Software drains the buffer; when it falls behind, the capture
    // latch keeps its pulses and the overrun flag tells software
    dmio_fifo #(
        .W           (dmio_pkg::DIN_W),
        .DEPTH       (dmio_pkg::FIFO_D)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (tick),
        .in_ready_o  (buf_ready),
        .in_data_i   (word),
        .out_valid_o (buf_valid),
        .out_ready_i (buf_pop),
        .out_data_o  (buf_word),
        .level_o     (buf_lvl)
    );

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        logic [31:0] wv;     // Merged write value
        logic        prep;   // Prepare command
        logic        start;  // Start command
        logic        stop;   // Stop command
        logic        rise;   // Index rising edge
        logic [1:0]  sw;     // Switch pair
        next_s = s;
        wv     = '0;
        prep   = 1'b0;
        start  = 1'b0;
        stop   = 1'b0;
        rise   = index_i && !s.idx_prev;
        sw     = 2'h0;

        // Bus answer: one ack per request, dropped the next cycle
        next_s.ack  = req;
        next_s.rdat = '0;

        // Register writes
        if (wr) begin
            if (dmio_hit(wb_req_i.adr, dmio_pkg::ADR_CTRL)) begin
                wv = dmio_merge({31'h0, s.no_index}, wb_req_i.dat, wb_req_i.sel);
                next_s.no_index = wv[dmio_pkg::CTRL_NOIDX];
            end else if (dmio_hit(wb_req_i.adr, dmio_pkg::ADR_CMD)) begin
                wv    = dmio_merge(32'h0, wb_req_i.dat, wb_req_i.sel);
                prep  = wv[dmio_pkg::CMD_PREP];
                start = wv[dmio_pkg::CMD_START];
                stop  = wv[dmio_pkg::CMD_STOP];
            end else if (dmio_hit(wb_req_i.adr, dmio_pkg::ADR_DIV)) begin
                wv = dmio_merge({16'h0, s.div}, wb_req_i.dat, wb_req_i.sel);
                next_s.div = wv[dmio_pkg::DIV_W-1:0];
            end else if (dmio_hit(wb_req_i.adr, dmio_pkg::ADR_INIT)) begin
                wv = dmio_merge({24'h0, s.init_val}, wb_req_i.dat, wb_req_i.sel);
                next_s.init_val = wv[dmio_pkg::DOUT_W-1:0];
            end else if (dmio_hit(wb_req_i.adr, dmio_pkg::ADR_DOUT)) begin
                // Before activation the value is only stored
                wv = dmio_merge({24'h0, s.dout}, wb_req_i.dat, wb_req_i.sel);
                next_s.dout = wv[dmio_pkg::DOUT_W-1:0];
            end else begin
                // Unmapped, data or status: nothing loaded here, still acked; status overrun clear is below
                wv = '0;
            end
        end

        // Register reads, captured into the answer flop
        if (rd) begin
            if (dmio_hit(wb_req_i.adr, dmio_pkg::ADR_CTRL)) begin
                next_s.rdat[dmio_pkg::CTRL_NOIDX] = s.no_index;
            end else if (dmio_hit(wb_req_i.adr, dmio_pkg::ADR_DIV)) begin
                next_s.rdat[dmio_pkg::DIV_W-1:0] = s.div;
            end else if (dmio_hit(wb_req_i.adr, dmio_pkg::ADR_INIT)) begin
                next_s.rdat[dmio_pkg::DOUT_W-1:0] = s.init_val;
            end else if (dmio_hit(wb_req_i.adr, dmio_pkg::ADR_DOUT)) begin
                next_s.rdat[dmio_pkg::DOUT_W-1:0] = s.dout;
            end else if (dmio_hit(wb_req_i.adr, dmio_pkg::ADR_STAT)) begin
                next_s.rdat[dmio_pkg::ST_ACT]  = s.out_act;
                next_s.rdat[dmio_pkg::ST_OD]   = s.od_mode;
                next_s.rdat[dmio_pkg::ST_MEAS] = s.measuring;
                next_s.rdat[dmio_pkg::ST_ARM]  = s.idx_arm;
                next_s.rdat[dmio_pkg::ST_CNT +: dmio_pkg::ENC_N] = s.cnt_en;
                next_s.rdat[dmio_pkg::ST_RNG +: dmio_pkg::GRP_N] = s.rng5;
                next_s.rdat[dmio_pkg::ST_OVR]  = s.overrun;
                next_s.rdat[dmio_pkg::ST_LVL +: LW] = buf_lvl;
            end else if (dmio_hit(wb_req_i.adr, dmio_pkg::ADR_DATA)) begin
                // Reading pops one whole port word
                next_s.rdat[dmio_pkg::DIN_W-1:0] = buf_valid ? buf_word : '0;
                next_s.rdat[dmio_pkg::DATA_VLD]  = buf_valid;
            end else begin
                // Command and unmapped offsets read as zero
                next_s.rdat = '0;
            end
        end

        // Overrun: a refused word sets it, write 1 clears; set wins
        if (wr && dmio_hit(wb_req_i.adr, dmio_pkg::ADR_STAT) && wb_req_i.sel[1]
            && wb_req_i.dat[dmio_pkg::ST_OVR]) begin
            next_s.overrun = 1'b0;
        end
        if (tick && !buf_ready) begin
            next_s.overrun = 1'b1;
        end

        // Sampling interval countdown
        if (s.measuring) begin
            next_s.tick_cnt = (s.tick_cnt == '0) ? s.div : s.tick_cnt - dmio_pkg::DIV_W'(1);
        end

        // Prepare: load the initial value, default LOW, and on the first
        // prepare after reset turn the drivers on with the pin's type
        if (prep) begin
            next_s.dout = s.init_val;
            if (!s.out_act) begin
                next_s.out_act = 1'b1;
                next_s.od_mode = driver_type_select_i;
            end
        end

        // Switch pairs come from the next value, so activation and the
        // first level land in one edge with no transient HIGH
        for (int i = 0; i < dmio_pkg::DOUT_W; i++) begin
            sw = dmio_drive(next_s.dout[i], next_s.od_mode, next_s.out_act);
            next_s.hs[i] = sw[1];
            next_s.ls[i] = sw[0];
        end

        // Index handling; the start-trigger state is deliberately unused
        next_s.idx_prev = index_i;
        if (s.idx_arm && rise) begin
            next_s.cnt_en  = '1;
            next_s.idx_arm = 1'b0;
        end

        // Start re-arms the index wait every time
        if (start) begin
            next_s.measuring = 1'b1;
            next_s.tick_cnt  = s.div;
            next_s.idx_arm   = !s.no_index;
            next_s.cnt_en    = s.no_index ? '1 : '0;
        end

        // Stop ends acquisition and holds the counters
        if (stop) begin
            next_s.measuring = 1'b0;
            next_s.idx_arm   = 1'b0;
            next_s.cnt_en    = '0;
        end

        // Range pins: open (pulled high) means 24 V
        next_s.rng5 = ~range_sel_n_i;
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s          <= '0;
            s.div      <= dmio_pkg::DIV_RST;
            s.init_val <= dmio_pkg::INIT_RST;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************************************
    // Outputs, all from flops
    // ****************************************************************
    assign wb_rsp_o.ack = s.ack;
    assign wb_rsp_o.dat = s.rdat;
    assign range_5v_o   = s.rng5;
    assign drv_high_o   = s.hs;
    assign drv_low_o    = s.ls;
    assign cnt_enable_o = s.cnt_en;

    // Trigger release state has no effect on the index wait
    logic unused_trig;
    assign unused_trig = start_trig_released_i;
endmodule : dmio_top

//--- hdl/dmio_pkg.sv
// ****************************************************************
// Shared constants and carriers
// ****************************************************************
package dmio_pkg;

    // Port widths
    localparam int unsigned DIN_W    = 16;        // Input port word
    localparam int unsigned DOUT_W   = 8;         // Output group
    localparam int unsigned ENC_N    = 4;         // Counter channels
    localparam int unsigned GRP_N    = 2;         // Input groups of eight
    localparam int unsigned FIFO_D   = 8;         // Sample buffer depth
    localparam int unsigned ADR_W    = 8;         // Bus byte address width
    localparam int unsigned DIV_W    = 16;        // Sample divider width

    // Timing: reset sampling rate at the system clock
    localparam int unsigned CLK_HZ   = 20_000_000;
    localparam int unsigned RATE_HZ  = 10_000;
    localparam logic [DIV_W-1:0] DIV_RST = DIV_W'(CLK_HZ / RATE_HZ - 1);

    // Register byte offsets
    localparam logic [ADR_W-1:0] ADR_CTRL = 8'h00;  // Mode bits
    localparam logic [ADR_W-1:0] ADR_CMD  = 8'h04;  // Command strobes
    localparam logic [ADR_W-1:0] ADR_DIV  = 8'h08;  // Sample interval
    localparam logic [ADR_W-1:0] ADR_INIT = 8'h0c;  // Initial output value
    localparam logic [ADR_W-1:0] ADR_DOUT = 8'h10;  // Output value
    localparam logic [ADR_W-1:0] ADR_STAT = 8'h14;  // Status
    localparam logic [ADR_W-1:0] ADR_DATA = 8'h18;  // Sample pop

    // Field positions
    localparam int unsigned CTRL_NOIDX = 0;   // No-index mode
    localparam int unsigned CMD_PREP   = 0;   // Prepare measurement
    localparam int unsigned CMD_START  = 1;   // Start measurement
    localparam int unsigned CMD_STOP   = 2;   // Stop measurement
    localparam int unsigned ST_ACT     = 0;   // Outputs active
    localparam int unsigned ST_OD      = 1;   // Open-drain latched
    localparam int unsigned ST_MEAS    = 2;   // Measuring
    localparam int unsigned ST_ARM     = 3;   // Waiting for index
    localparam int unsigned ST_CNT     = 4;   // Counter enables, 4 bits
    localparam int unsigned ST_RNG     = 8;   // 5 V range flags, 2 bits
    localparam int unsigned ST_OVR     = 10;  // Sample overrun, write 1 clears
    localparam int unsigned ST_LVL     = 16;  // Buffer fill level
    localparam int unsigned DATA_VLD   = 16;  // Popped word was valid

    // Reset values
    localparam logic [DOUT_W-1:0] INIT_RST = 8'h00;

    // Wishbone request and answer
    typedef struct packed {
        logic             cyc;
        logic             stb;
        logic             we;
        logic [3:0]       sel;
        logic [ADR_W-1:0] adr;
        logic [31:0]      dat;
    } dmio_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } dmio_wb_rsp_t;

endpackage : dmio_pkg

//--- hdl/dmio_fifo.sv
`timescale 1ns/100ps
// ****************************************************************
// Sample buffer
// ****************************************************************
module dmio_fifo #(
    parameter int unsigned W     = 16,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o,
    output logic [$clog2(DEPTH+1)-1:0] level_o
);
    localparam int unsigned PW = $clog2(DEPTH);
    localparam int unsigned CW = $clog2(DEPTH+1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;   // Storage words
        logic [PW-1:0]           wp;    // Write index
        logic [PW-1:0]           rp;    // Read index
        logic [CW-1:0]           cnt;   // Words held
    } dmio_fifo_st_t;

    dmio_fifo_st_t s;
    dmio_fifo_st_t next_s;
    logic          push;
    logic          pop;

    // Honest flags straight from the count
    assign in_ready_o  = (s.cnt != CW'(DEPTH));
    assign out_valid_o = (s.cnt != '0);
    assign out_data_o  = s.mem[s.rp];
    assign level_o     = s.cnt;
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_ready_i & out_valid_o;

    // Pointer and count update, wrap at depth
    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wp] = in_data_i;
            next_s.wp = (s.wp == PW'(DEPTH-1)) ? '0 : s.wp + PW'(1);
        end
        if (pop) begin
            next_s.rp = (s.rp == PW'(DEPTH-1)) ? '0 : s.rp + PW'(1);
        end
        next_s.cnt = s.cnt + CW'(push) - CW'(pop);
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule : dmio_fifo

//--- hdl/dmio_capture.sv
`timescale 1ns/100ps
// ****************************************************************
// Input port capture with short-pulse catching
// ****************************************************************
module dmio_capture #(
    parameter int unsigned W = 16
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] din_i,     // Conditioned input levels
    input  wire logic         tick_i,    // End of a sampling interval
    input  wire logic         accept_i,  // Buffer takes the word
    output logic [W-1:0]      word_o     // Whole port word
);
    typedef struct packed {
        logic [W-1:0] held;   // HIGH seen since last recorded word
    } dmio_cap_st_t;

    dmio_cap_st_t s;
    dmio_cap_st_t next_s;

    // The word always carries the current level too, so a pulse in the
    // recording cycle itself is not lost when the latch is cleared
    assign word_o = s.held | din_i;

    // Catch HIGH levels; clear only once the word really went out, so a
    // refused word keeps its pulses for the next interval
    always_comb begin
        next_s = s;
        if (tick_i && accept_i) begin
            next_s.held = '0;
        end else begin
            next_s.held = s.held | din_i;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule : dmio_capture

//--- verif/dmio_field.sv
`timescale 1ns/100ps
// ****
// Field side: sensors and encoder
// ****
module dmio_field (
    input  wire logic   clk_i,
    output logic [15:0] din_o,         // Open inputs are pulled down
    output logic        index_o,       // Shared index track
    output logic [1:0]  range_sel_n_o  // Group 1 jumpered to common
);
    initial begin
        din_o = 16'h0000;
        index_o = 1'b0;
        range_sel_n_o = 2'b01;
    end
    // One-cycle HIGH, far shorter than an interval
    task automatic pulse(input logic [15:0] m);
        @(posedge clk_i) din_o <= m;
        @(posedge clk_i) din_o <= 16'h0000;
    endtask : pulse
    // Index rises, stays two cycles, falls
    task automatic index_rise();
        @(posedge clk_i) index_o <= 1'b1;
        repeat (2) @(posedge clk_i);
        index_o <= 1'b0;
    endtask : index_rise
endmodule : dmio_field

//--- verif/dmio_chk.sv
`timescale 1ns/100ps
// ****
// Port checker
// ****
module dmio_chk (
    input wire logic                   clk_i,
    input wire logic                   rst_i,
    input wire dmio_pkg::dmio_wb_req_t wb_req_i,
    input wire dmio_pkg::dmio_wb_rsp_t wb_rsp_o,
    input wire logic [1:0]             range_sel_n_i,
    input wire logic [1:0]             range_5v_o,
    input wire logic [7:0]             drv_high_o,
    input wire logic [7:0]             drv_low_o,
    input wire logic                   index_i,
    input wire logic [3:0]             cnt_enable_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Both switches on would short the driver supply
    AST_NO_SHORT: assert property ((drv_high_o & drv_low_o) == 8'h00)
        else $error("both switches on");
    AST_HIZ: assert property ($past(rst_i) |-> {drv_high_o, drv_low_o} == 16'h0000)
        else $error("driver on after reset");
    AST_RANGE: assert property (!$past(rst_i) |-> range_5v_o == ~$past(range_sel_n_i))
        else $error("range flag wrong");
    AST_CNT_ALL: assert property (cnt_enable_o inside {4'h0, 4'hf})
        else $error("counters split");
    AST_CNT_RISE: assert property ($rose(cnt_enable_o[0]) |->
        wb_rsp_o.ack || ($past(index_i) && !$past(index_i, 2))) else $error("counters start uncaused");
    AST_ACK_ONE: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("ack too long");
    AST_ACK_NEXT: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack)
        else $error("ack late");
    AST_DRV_HOLD: assert property (!$past(rst_i) && !$stable({drv_high_o, drv_low_o}) |-> wb_rsp_o.ack)
        else $error("drivers moved without write");
    AST_WAKE: assert property ($past({drv_high_o, drv_low_o}) == 16'h0000 &&
        {drv_high_o, drv_low_o} != 16'h0000 |-> $past(wb_req_i.we)) else $error("woke without write");
    cover property ($rose(cnt_enable_o[0]));
    cover property (drv_low_o != 8'h00);
    cover property (wb_rsp_o.ack && wb_req_i.we);
endmodule : dmio_chk
bind dmio_top dmio_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
    .range_sel_n_i(range_sel_n_i), .range_5v_o(range_5v_o), .drv_high_o(drv_high_o),
    .drv_low_o(drv_low_o), .index_i(index_i), .cnt_enable_o(cnt_enable_o));

//--- verif/digital_multiboard_io_control_test.sv
`timescale 1ns/100ps
// ****
// Bench
// ****
module digital_multiboard_io_control_test;
    logic                   clk_i = 1'b0;
    logic                   rst_i = 1'b1;
    logic                   drv_sel = 1'b0;  // Low: push-pull
    logic                   trig_rel = 1'b0;
    dmio_pkg::dmio_wb_req_t wb_req = '0;
    dmio_pkg::dmio_wb_rsp_t wb_rsp;
    logic [15:0]            din;
    logic                   index;
    logic [1:0]             rsel_n, rng;
    logic [7:0]             hi, lo;
    logic [3:0]             cnt;
    logic [31:0]            rd;              // Last read data
    int                     mismatches = 0, n_compared = 0, cycles = 0;

    dmio_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp), .din_i(din),
        .range_sel_n_i(rsel_n), .range_5v_o(rng), .driver_type_select_i(drv_sel), .drv_high_o(hi),
        .drv_low_o(lo), .index_i(index), .start_trig_released_i(trig_rel), .cnt_enable_o(cnt));
    dmio_field field (.clk_i(clk_i), .din_o(din), .index_o(index), .range_sel_n_o(rsel_n));

    initial forever #25 clk_i = ~clk_i;
    // A hang ends the run as a failure
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            conclude();
        end
    end
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Classic cycle: hold until ack, take data at that edge
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_req <= '{1'b1, 1'b1, we, 4'hf, a, d};
        do @(posedge clk_i); while (wb_rsp.ack !== 1'b1);
        rd = wb_rsp.dat;
        wb_req <= '0;
    endtask : bus
    task automatic reset(input int n);
        rst_i <= 1'b1;
        repeat (n) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask : reset

    initial begin
        reset(10);
        chk("drivers", 32'h0, 32'({hi, lo}));
        bus(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, rd);
        chk("range", 32'h2, 32'(rng));
        $display("test reset ends");
        bus(1'b1, 8'h04, 32'h1);
        chk("pp low", 32'h00ff, 32'({hi, lo}));
        drv_sel <= 1'b1;
        bus(1'b1, 8'h10, 32'h0f);
        @(posedge clk_i);
        chk("pp kept", 32'h0ff0, 32'({hi, lo}));
        bus(1'b1, 8'h0c, 32'h3c);
        bus(1'b1, 8'h04, 32'h1);
        chk("reprep", 32'h3cc3, 32'({hi, lo}));
        reset(2);
        bus(1'b1, 8'h0c, 32'ha5);
        chk("stored", 32'h0, 32'({hi, lo}));
        bus(1'b1, 8'h04, 32'h1);
        chk("od", 32'h005a, 32'({hi, lo}));
        $display("test outputs ends");
        // Interval of 16 cycles; nine intervals overfill the buffer
        bus(1'b1, 8'h08, 32'd15);
        bus(1'b1, 8'h04, 32'h2);
        field.pulse(16'h1008);
        trig_rel <= 1'b1;
        repeat (150) @(posedge clk_i);
        chk("waiting", 32'h0, 32'(cnt));
        field.index_rise();
        chk("index", 32'hf, 32'(cnt));
        bus(1'b0, 8'h14, 32'h0);
        chk("full", 32'h11, 32'({rd[19:16], rd[10]}));
        bus(1'b1, 8'h04, 32'h4);
        for (int i = 0; i < 9; i++) begin
            bus(1'b0, 8'h18, 32'h0);
            chk("pop", (i == 0) ? 32'h11008 : (i < 8) ? 32'h10000 : 32'h0, rd);
        end
        bus(1'b1, 8'h04, 32'h2);
        chk("rearmed", 32'h0, 32'(cnt));
        field.index_rise();
        chk("index again", 32'hf, 32'(cnt));
        $display("test sampling ends");
        bus(1'b1, 8'h04, 32'h4);
        bus(1'b1, 8'h00, 32'h1);  // Encoder without index track
        bus(1'b1, 8'h04, 32'h2);
        chk("no index", 32'hf, 32'(cnt));
        $display("test no index ends");
        conclude();
    end
endmodule : digital_multiboard_io_control_test
